// ---- logic/irq_level_pkg.sv ----
package irq_level_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register geometry
   localparam int REG_W = 16;
   localparam int FIELD_W = 2;
   localparam int FIELDS_PER_REG = 8;
   localparam int NUM_REGS = 4;
   localparam int NUM_SRC = 32;

   // printed word offsets; byte address is four times the index
   localparam logic [3:0] DECODER_TIMER_IRQ_LEVEL_IDX = 4'h6;
   localparam logic [3:0] TIMER_IRQ_LEVEL_IDX = 4'h7;
   localparam logic [3:0] SERIAL_TIMER_IRQ_LEVEL_IDX = 4'h8;
   localparam logic [3:0] PWM_ADC_IRQ_LEVEL_IDX = 4'h9;
   localparam logic [3:0] FIRST_IDX = DECODER_TIMER_IRQ_LEVEL_IDX;
   localparam int BYTE_SHIFT = 2;

   // reset value of every field register
   localparam logic [15:0] LEVEL_REG_RESET = 16'h0000;

   // writable bit masks; clear bits are reserved and read zero
   localparam logic [15:0] DECODER_TIMER_WMASK = 16'h000F;
   localparam logic [15:0] TIMER_WMASK = 16'hFFFF;
   localparam logic [15:0] SERIAL_TIMER_WMASK = 16'hF3FF;
   localparam logic [15:0] PWM_ADC_WMASK = 16'hFFFF;

   // field codes
   localparam logic [1:0] FIELD_MASKED = 2'h0;
   localparam logic [1:0] FIELD_LEVEL0 = 2'h1;
   localparam logic [1:0] FIELD_LEVEL1 = 2'h2;
   localparam logic [1:0] FIELD_LEVEL2 = 2'h3;
   localparam logic [1:0] LEVEL_0 = 2'h0;
   localparam logic [1:0] LEVEL_1 = 2'h1;
   localparam logic [1:0] LEVEL_2 = 2'h2;

   localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

endpackage

// ---- logic/irq_level_decode.sv ----
////////////////////////////////////////////////////////////////////////////////
// decodes packed two-bit fields into enable and level per source
module irq_level_decode #(
   parameter int NUM_SRC = 32
) (
   // packed fields, source n at bits 2n+1:2n
   input wire logic [2*NUM_SRC-1:0] fields,
   // decoded outputs
   output logic [NUM_SRC-1:0] src_enable,
   output logic [2*NUM_SRC-1:0] src_level
);

   genvar g;
   generate
      for (g = 0; g < NUM_SRC; g++)
      begin : gen_src
         logic [1:0] f;
         assign f = fields[2*g +: 2];
         // masked source shows enable low and level zero, never a live level
         assign src_enable[g] = (f != irq_level_pkg::FIELD_MASKED);
         // code minus one; code 00 is excluded so level tops out at 2
         assign src_level[2*g +: 2] = (f == irq_level_pkg::FIELD_LEVEL0) ? irq_level_pkg::LEVEL_0 :
                                      (f == irq_level_pkg::FIELD_LEVEL1) ? irq_level_pkg::LEVEL_1 :
                                      (f == irq_level_pkg::FIELD_LEVEL2) ? irq_level_pkg::LEVEL_2 :
                                      irq_level_pkg::LEVEL_0;
      end
   endgenerate

endmodule // irq_level_decode

// ---- logic/irq_priority_level_regs.sv ----
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - field 00 masks, 01 level 0, 10 level 1, 11 level 2
// - reset clears all fields to 00, every source disabled
// - no field assigns a level above 2
// - reserved bits read zero and ignore writes, incl. bits 11-10 at offset 8
// - offset 7: timer A ch0, timer B ch3..0, timer C ch3..1 from top down
// - offset 8: serial rx full, rx error, tx idle, tx empty, timer A ch3..1
// - offset 9 top: PWM A fault, PWM B fault, PWM A reload
// - offset 6: decoder 0 index at 3-2, home or watchdog at 1-0
// - offset 9 low: PWM B reload, ADC A/B zero cross, ADC A/B done
//
// Added by the designer: the APB slave port.
module irq_priority_level_regs (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // decoded sources, index order given in the header of each register below
   output logic [31:0] src_enable,
   output logic [63:0] src_level
);

   ////////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      logic [3:0][15:0] regs;
      logic [31:0] rdata;
   } state_t;

   state_t s_q;
   state_t s_d;

   logic [3:0] idx;
   logic hit;
   logic [15:0] wmask [4];
   logic setup;

   assign wmask[0] = irq_level_pkg::DECODER_TIMER_WMASK;
   assign wmask[1] = irq_level_pkg::TIMER_WMASK;
   assign wmask[2] = irq_level_pkg::SERIAL_TIMER_WMASK;
   assign wmask[3] = irq_level_pkg::PWM_ADC_WMASK;

   ////////////////////////////////////////////////////////////////////////////
   // address decode: word index of the byte address, offsets 6 to 9
   assign idx = paddr[irq_level_pkg::BYTE_SHIFT +: 4];
   assign hit = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0) &&
                (idx >= irq_level_pkg::DECODER_TIMER_IRQ_LEVEL_IDX) &&
                (idx <= irq_level_pkg::PWM_ADC_IRQ_LEVEL_IDX);
   assign setup = psel && !penable;

   // zero wait states; unmapped address answers with error
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign prdata = s_q.rdata;

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      logic [1:0] r;
      logic [15:0] wv;
      r = 2'(idx - irq_level_pkg::FIRST_IDX);
      wv = s_q.regs[r];
      s_d = s_q;
      // write lands in the access cycle; only lanes 0 and 1 carry the word
      if (psel && penable && pwrite && hit)
      begin
         if (pstrb[0])
            wv[7:0] = pwdata[7:0];
         if (pstrb[1])
            wv[15:8] = pwdata[15:8];
         s_d.regs[r] = wv & wmask[r];
      end
      // read data captured in setup so it is stable during access
      if (setup)
      begin
         if (!pwrite && hit)
            s_d.rdata = {16'h0000, s_q.regs[r] & wmask[r]};
         else
            s_d.rdata = irq_level_pkg::RDATA_IDLE;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q.regs <= {4{irq_level_pkg::LEVEL_REG_RESET}};
         s_q.rdata <= irq_level_pkg::RDATA_IDLE;
      end
      else
         s_q <= s_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // source packing, two bits per source, src n at fields[2n+1:2n]
   // 0 decoder0_home_watchdog, 1 decoder0_index            (reg 6 bits 3-0)
   // 2..9  timer_c_ch1..3, timer_b_ch0..3, timer_a_ch0     (reg 7 bits 1-0 up)
   // 10..12 timer_a_ch1..3, 13 tx empty, 14 tx idle,
   // 15 rx error, 16 rx full                               (reg 8)
   // 17 adc_b_done, 18 adc_a_done, 19 adc_b_zc, 20 adc_a_zc,
   // 21 pwm_b_reload, 22 pwm_a_reload, 23 pwm_b_fault, 24 pwm_a_fault (reg 9)
   // one named level per source
   logic [1:0] decoder0_index_level;
   logic [1:0] decoder0_home_watchdog_level;
   logic [1:0] timer_a_ch0_level;
   logic [1:0] timer_a_ch1_level;
   logic [1:0] timer_a_ch2_level;
   logic [1:0] timer_a_ch3_level;
   logic [1:0] timer_b_ch0_level;
   logic [1:0] timer_b_ch1_level;
   logic [1:0] timer_b_ch2_level;
   logic [1:0] timer_b_ch3_level;
   logic [1:0] timer_c_ch1_level;
   logic [1:0] timer_c_ch2_level;
   logic [1:0] timer_c_ch3_level;
   logic [1:0] serial0_rx_full_level;
   logic [1:0] serial0_rx_error_level;
   logic [1:0] serial0_tx_idle_level;
   logic [1:0] serial0_tx_empty_level;
   logic [1:0] pwm_a_fault_level;
   logic [1:0] pwm_b_fault_level;
   logic [1:0] pwm_a_reload_level;
   logic [1:0] pwm_b_reload_level;
   logic [1:0] adc_a_zero_cross_level;
   logic [1:0] adc_b_zero_cross_level;
   logic [1:0] adc_a_conv_done_level;
   logic [1:0] adc_b_conv_done_level;
   logic [63:0] fields;

   // decoder 0 sits in the low nibble; the rest of that word is not built
   assign decoder0_index_level = s_q.regs[0][3:2];
   assign decoder0_home_watchdog_level = s_q.regs[0][1:0];

   // timer A ch0 on top, then timer B ch3 to ch0, then timer C ch3 to ch1
   assign timer_a_ch0_level = s_q.regs[1][15:14];
   assign timer_b_ch3_level = s_q.regs[1][13:12];
   assign timer_b_ch2_level = s_q.regs[1][11:10];
   assign timer_b_ch1_level = s_q.regs[1][9:8];
   assign timer_b_ch0_level = s_q.regs[1][7:6];
   assign timer_c_ch3_level = s_q.regs[1][5:4];
   assign timer_c_ch2_level = s_q.regs[1][3:2];
   assign timer_c_ch1_level = s_q.regs[1][1:0];

   // serial port 0 on top; the pair at 11-10 never reaches a source
   assign serial0_rx_full_level = s_q.regs[2][15:14];
   assign serial0_rx_error_level = s_q.regs[2][13:12];
   assign serial0_tx_idle_level = s_q.regs[2][9:8];
   assign serial0_tx_empty_level = s_q.regs[2][7:6];
   assign timer_a_ch3_level = s_q.regs[2][5:4];
   assign timer_a_ch2_level = s_q.regs[2][3:2];
   assign timer_a_ch1_level = s_q.regs[2][1:0];

   // pwm faults and reloads on top, adc events below
   assign pwm_a_fault_level = s_q.regs[3][15:14];
   assign pwm_b_fault_level = s_q.regs[3][13:12];
   assign pwm_a_reload_level = s_q.regs[3][11:10];
   assign pwm_b_reload_level = s_q.regs[3][9:8];
   assign adc_a_zero_cross_level = s_q.regs[3][7:6];
   assign adc_b_zero_cross_level = s_q.regs[3][5:4];
   assign adc_a_conv_done_level = s_q.regs[3][3:2];
   assign adc_b_conv_done_level = s_q.regs[3][1:0];

   // packed view for the decoder, top source first; indices 25 to 31 stay empty
   assign fields = {
      14'h0000,
      pwm_a_fault_level, pwm_b_fault_level, pwm_a_reload_level, pwm_b_reload_level,
      adc_a_zero_cross_level, adc_b_zero_cross_level,
      adc_a_conv_done_level, adc_b_conv_done_level,
      serial0_rx_full_level, serial0_rx_error_level,
      serial0_tx_idle_level, serial0_tx_empty_level,
      timer_a_ch3_level, timer_a_ch2_level, timer_a_ch1_level, timer_a_ch0_level,
      timer_b_ch3_level, timer_b_ch2_level, timer_b_ch1_level, timer_b_ch0_level,
      timer_c_ch3_level, timer_c_ch2_level, timer_c_ch1_level,
      decoder0_index_level, decoder0_home_watchdog_level
   };

   irq_level_decode #(
      .NUM_SRC(irq_level_pkg::NUM_SRC)
   ) u_decode (
      .fields(fields),
      .src_enable(src_enable),
      .src_level(src_level)
   );

   ////////////////////////////////////////////////////////////////////////////
   // checks
   AST_RESET_CLEAR: assert property (@(posedge pclk)
      $rose(presetn) |-> (src_enable == 32'h0000_0000))
      else $error("sources enabled right after reset");

   AST_RESET_LEVELS: assert property (@(posedge pclk)
      $rose(presetn) |-> (src_level == 64'h0000_0000_0000_0000))
      else $error("levels live right after reset");

   AST_MASKED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      (fields[1:0] == 2'h0) |-> (!src_enable[0] && src_level[1:0] == 2'h0))
      else $error("masked source not blocked");

   AST_NO_GHOST: assert property (@(posedge pclk) disable iff (!presetn)
      src_enable[31:25] == 7'h00 && src_level[63:50] == 14'h0000)
      else $error("unused source index active");

   AST_LEVEL_MAX: assert property (@(posedge pclk) disable iff (!presetn)
      src_level[49:48] != 2'h3)
      else $error("level above 2");

   AST_DECODE: assert property (@(posedge pclk) disable iff (!presetn)
      (s_q.regs[1][15:14] == 2'h3) |->
      (src_enable[9] && src_level[19:18] == 2'h2))
      else $error("timer a ch0 decode wrong");

   AST_LEVEL0_CODE: assert property (@(posedge pclk) disable iff (!presetn)
      (s_q.regs[3][1:0] == 2'h1) |-> (src_enable[17] && src_level[35:34] == 2'h0))
      else $error("code 01 not level 0");

   AST_LEVEL1_CODE: assert property (@(posedge pclk) disable iff (!presetn)
      (s_q.regs[2][15:14] == 2'h2) |-> (src_enable[16] && src_level[33:32] == 2'h1))
      else $error("code 10 not level 1");

   AST_RESERVED: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.regs[2][11:10] == 2'h0 && s_q.regs[0][15:4] == 12'h000)
      else $error("reserved bits stored");

   AST_RESERVED_READ: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite && hit && idx == irq_level_pkg::SERIAL_TIMER_IRQ_LEVEL_IDX)
      |-> (prdata[11:10] == 2'h0 && prdata[31:16] == 16'h0000))
      else $error("reserved bits read back");

   AST_WRITE_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && !hit) |=> $stable(s_q.regs))
      else $error("refused write changed a field");

   AST_WRITE_TAKES: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && hit && pstrb[1] &&
       idx == irq_level_pkg::SERIAL_TIMER_IRQ_LEVEL_IDX)
      |=> (s_q.regs[2][15:14] == $past(pwdata[15:14])))
      else $error("rx full field not written");

   AST_READ_DATA: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite && hit && idx == irq_level_pkg::TIMER_IRQ_LEVEL_IDX)
      |-> (prdata == {16'h0000, s_q.regs[1]}))
      else $error("timer register read wrong");

   AST_DEC_HOME_MAP: assert property (@(posedge pclk) disable iff (!presetn)
      src_enable[0] == (s_q.regs[0][1:0] != 2'h0))
      else $error("decoder home mapping wrong");

   AST_DEC_MAP: assert property (@(posedge pclk) disable iff (!presetn)
      src_enable[1] == (s_q.regs[0][3:2] != 2'h0))
      else $error("decoder index mapping wrong");

   AST_TIMER_C1_MAP: assert property (@(posedge pclk) disable iff (!presetn)
      src_enable[2] == (s_q.regs[1][1:0] != 2'h0))
      else $error("timer c ch1 mapping wrong");

   AST_TIMER_B3_MAP: assert property (@(posedge pclk) disable iff (!presetn)
      src_enable[8] == (s_q.regs[1][13:12] != 2'h0))
      else $error("timer b ch3 mapping wrong");

   AST_TIMER_A1_MAP: assert property (@(posedge pclk) disable iff (!presetn)
      src_enable[10] == (s_q.regs[2][1:0] != 2'h0))
      else $error("timer a ch1 mapping wrong");

   AST_TX_EMPTY_MAP: assert property (@(posedge pclk) disable iff (!presetn)
      src_enable[13] == (s_q.regs[2][7:6] != 2'h0))
      else $error("tx empty mapping wrong");

   AST_TX_IDLE_MAP: assert property (@(posedge pclk) disable iff (!presetn)
      src_enable[14] == (s_q.regs[2][9:8] != 2'h0))
      else $error("tx idle mapping wrong");

   AST_RX_ERROR_MAP: assert property (@(posedge pclk) disable iff (!presetn)
      src_enable[15] == (s_q.regs[2][13:12] != 2'h0))
      else $error("rx error mapping wrong");

   AST_RX_FULL_MAP: assert property (@(posedge pclk) disable iff (!presetn)
      src_enable[16] == (s_q.regs[2][15:14] != 2'h0))
      else $error("rx full mapping wrong");

   AST_ADC_MAP: assert property (@(posedge pclk) disable iff (!presetn)
      src_enable[17] == (s_q.regs[3][1:0] != 2'h0))
      else $error("adc b done mapping wrong");

   AST_ADC_ZC_MAP: assert property (@(posedge pclk) disable iff (!presetn)
      src_enable[20] == (s_q.regs[3][7:6] != 2'h0))
      else $error("adc a zero cross mapping wrong");

   AST_PWM_RELOAD_MAP: assert property (@(posedge pclk) disable iff (!presetn)
      src_enable[22] == (s_q.regs[3][11:10] != 2'h0))
      else $error("pwm a reload mapping wrong");

   AST_PWM_B_FAULT_MAP: assert property (@(posedge pclk) disable iff (!presetn)
      src_enable[23] == (s_q.regs[3][13:12] != 2'h0))
      else $error("pwm b fault mapping wrong");

   AST_PWM_MAP: assert property (@(posedge pclk) disable iff (!presetn)
      src_enable[24] == (s_q.regs[3][15:14] != 2'h0))
      else $error("pwm a fault mapping wrong");

   // every source index, so a slip in the decoder cannot hide behind one probe
   for (genvar g = 0; g < irq_level_pkg::NUM_SRC; g++)
   begin : gen_cap
      AST_LEVEL_CAP: assert property (@(posedge pclk) disable iff (!presetn)
         src_level[2*g +: 2] != 2'h3)
         else $error("decoded level above 2");
   end

endmodule // irq_priority_level_regs

// ---- bench/irq_arbiter_model.sv ----
////////////////////////////////////////////////////////////////////////////////
// far side: the core's arbitration sees only enabled sources
module irq_arbiter_model (
   // decoded sources
   input wire logic [31:0] src_enable,
   input wire logic [63:0] src_level,
   // request towards the core
   output logic any_req,
   output logic [1:0] top_level
);
   timeunit 1ns;
   timeprecision 1ps;
   // a masked source must never compete, whatever its level bits hold
   always_comb
   begin
      any_req = |src_enable;
      top_level = 2'h0;
      for (int n = 0; n < 32; n++)
         if (src_enable[n] && src_level[2*n+:2] > top_level)
            top_level = src_level[2*n+:2];
   end
endmodule // irq_arbiter_model

// ---- bench/irq_priority_level_regs_test.sv ----
module irq_priority_level_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, any_req, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, src_enable, rd;
   logic [3:0] pstrb;
   logic [63:0] src_level;
   logic [1:0] top;
   logic [15:0] mdl [6:9];
   int fail_count, checked;
   irq_priority_level_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .src_enable(src_enable), .src_level(src_level));
   irq_arbiter_model far (.src_enable(src_enable), .src_level(src_level), .any_req(any_req),
      .top_level(top));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // sources in output order, reserved bits left out
   function automatic logic [63:0] fields();
      return {14'h0, mdl[9], mdl[8][15:12], mdl[8][9:0], mdl[7], mdl[6][3:0]};
   endfunction
   function automatic logic [15:0] wmask(input int i);
      case (i)
         6: return irq_level_pkg::DECODER_TIMER_WMASK;
         8: return irq_level_pkg::SERIAL_TIMER_WMASK;
         default: return 16'hFFFF;
      endcase
   endfunction
   task automatic wr_reg(input int i, input logic [15:0] d, input logic [3:0] s);
      logic [15:0] m;
      m = {{8{s[1]}}, {8{s[0]}}} & wmask(i);
      apb(1'b1, 12'(i << 2), {16'hFFFF, d}, s);
      chk(64'(err), 64'h0);
      mdl[i] = (mdl[i] & ~m) | (d & m);
   endtask
   task automatic check_regs();
      logic [63:0] f, lv;
      logic [31:0] en;
      logic [1:0] tl;
      f = fields();
      tl = 2'h0;
      for (int n = 0; n < 32; n++)
      begin
         en[n] = |f[2*n+:2];
         lv[2*n+:2] = en[n] ? f[2*n+:2] - 2'h1 : 2'h0;
         if (en[n] && lv[2*n+:2] > tl)
            tl = lv[2*n+:2];
      end
      for (int i = 6; i < 10; i++)
      begin
         apb(1'b0, 12'(i << 2), 32'h0, 4'h0);
         chk(64'(rd), {48'h0, mdl[i]});
      end
      chk(64'(src_enable), 64'(en));
      chk(src_level, lv);
      chk(64'(any_req), 64'(|en));
      chk(64'(top), 64'(tl));
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // cut a hang short at 10000 cycles, far beyond the roughly 730 cycles the tests need
   initial
   begin
      #200000;
      fail_count++;
      give_verdict();
   end
   initial
   begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      foreach (mdl[i]) mdl[i] = 16'h0;
      void'($urandom(76));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      check_regs();
      $display("test reset done");
      // every code in every field; every pass after the first also hits reserved bits
      for (int c = 0; c < 4; c++)
      begin
         for (int i = 6; i < 10; i++)
            wr_reg(i, {8{2'(c)}}, 4'h3);
         check_regs();
      end
      $display("test codes done");
      // refused addresses must leave every field alone
      apb(1'b1, 12'h01A, 32'hFFFF, 4'hF);
      chk(64'(err), 64'h1);
      apb(1'b0, 12'h028, 32'h0, 4'h0);
      chk(64'(err), 64'h1);
      chk(64'(rd), 64'h0);
      check_regs();
      $display("test refuse done");
      repeat (40)
      begin
         wr_reg($urandom_range(9, 6), 16'($urandom), 4'($urandom));
         check_regs();
      end
      $display("test random done");
      give_verdict();
   end
endmodule // irq_priority_level_regs_test
